/* File: rtl/brc_defines.svh */
// Offsets, field positions, reset values and timing counts for buck control
`ifndef BRC_DEFINES_SVH
`define BRC_DEFINES_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define BRC_ADDR_ENABLE 8'h00
`define BRC_ADDR_CONFIG 8'h04
`define BRC_ADDR_MODE 8'h08
`define BRC_ADDR_INT_STATUS 8'h0c
`define BRC_ADDR_INT_MASK 8'h10
`define BRC_ADDR_STATUS 8'h14
`define BRC_ADDR_RESOLUTION 8'h18
`define BRC_ADDR_SET_A_BASE 8'h20
`define BRC_ADDR_SET_B_BASE 8'h30
`define BRC_ADDR_CODE_BASE 8'h40

// ----------------------------------------------------------------
// Config register fields
// ----------------------------------------------------------------
`define BRC_CFG_SLOW_START 0
`define BRC_CFG_DISCHARGE 1
`define BRC_CFG_FIRST_FCM 2
`define BRC_CFG_SECOND_FCM 3
`define BRC_CFG_SECOND_PD_DIS 4
`define BRC_CFG_TERM_EN 5
`define BRC_CFG_TERM_REF_EN 6
`define BRC_CFG_STEP_LSB 8
`define BRC_CFG_RESET 32'h0000_000c

// ----------------------------------------------------------------
// Mode field encodings and resolution
// ----------------------------------------------------------------
`define BRC_MODE_AUTO 2'h0
`define BRC_MODE_PWM 2'h1
`define BRC_MODE_PFM 2'h2
`define BRC_STEP_MV_NORMAL 8'h0a
`define BRC_STEP_MV_THIRD 8'h14

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define BRC_CLK_PERIOD_NS 20
`define BRC_STEP_UNIT_NS 250
`define BRC_STEP_UNIT_CYC (`BRC_STEP_UNIT_NS / `BRC_CLK_PERIOD_NS)

`endif

/* File: rtl/brc_pkg.sv */
// Types shared by the buck regulator control block
package brc_pkg;

  // Register port request from software
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } brc_bus_req_t;

  // Per-converter software controls
  typedef struct packed {
    logic en;
    logic sel;
    logic sl_a;
    logic sl_b;
    logic [1:0] mode;
    logic [1:0] ilim;
  } brc_conv_ctrl_t;

  // Fourth converter reference source, one-hot
  typedef enum logic [2:0] {
    BRC_REF_DAC = 3'h1,
    BRC_REF_HALF_RAW = 3'h2,
    BRC_REF_HALF_BUF = 3'h4
  } brc_ref_t;

endpackage : brc_pkg

/* File: rtl/brc_buck_control.sv */
// Control logic for four step-down converters with stepped voltage ramping
// Summary of operation
// - Enable from register, input pin, or sequencer
// - Two settings; select by bit, pin, mode
// - Code step 10 mV, third converter 20
// - Ramp code one step per shared step time
// - Ready event when all converters reach target
// - Fast start by default; slow start ramps
// - Discharge off converter by ramping code down
// - Current limit field caps duty, never stops
// - Mode field: forced PWM, PFM, or auto
// - Sleep forced when linked setting is active
// - First two converters: full or half current
// - Merge ignores second register controls except pull-down
// - Termination bits choose fourth converter reference
// - Termination bits give pins analog functions
// - Analog pins lose their digital functions
// - Setting writes accepted only in active mode
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "brc_defines.svh"

module brc_buck_control #(
  parameter int NUM_CONV = 4,
  parameter int CODE_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire brc_pkg::brc_bus_req_t bus_req,
  output logic [31:0] bus_rdata,
  input wire logic [NUM_CONV-1:0] pin_enable,
  input wire logic [NUM_CONV-1:0] pin_select,
  input wire logic [NUM_CONV-1:0] pin_light_load,
  input wire logic [NUM_CONV-1:0] seq_enable,
  input wire logic [NUM_CONV-1:0] seq_select_b,
  input wire logic power_active,
  input wire logic dual_phase_merge,
  input wire logic [1:0] io_pad_in,
  input wire logic [1:0] io_dig_out,
  input wire logic [1:0] io_dig_oe,
  output logic [1:0] io_pad_out,
  output logic [1:0] io_pad_oe,
  output logic [1:0] io_dig_in,
  output logic [NUM_CONV-1:0][CODE_W-1:0] conv_code,
  output logic [NUM_CONV-1:0] conv_on,
  output logic [NUM_CONV-1:0] conv_pfm,
  output logic [NUM_CONV-1:0][1:0] peak_current_limit,
  output logic [1:0] full_current_select,
  output logic second_pulldown_disable,
  output brc_pkg::brc_ref_t fourth_ref_select,
  output logic io_pin_zero_analog,
  output logic io_pin_one_analog,
  output logic irq
);

  localparam int PIN_W = 3 * NUM_CONV + 2;

  // ----------------------------------------------------------------
  // Register state and pin synchronisers
  // ----------------------------------------------------------------
  logic [31:0] enable_reg, config_reg, mode_reg, rdata_next, rdata_reg;
  logic int_status_reg, int_mask_reg, wr_setting;
  logic [NUM_CONV-1:0][CODE_W-1:0] set_a_reg, set_b_reg;
  logic [7:0] step_time;
  logic [PIN_W-1:0] sync1_reg, sync2_reg, sync3_reg, pin_reg;

  // Three stages; a level is taken only once stages two and three agree
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {sync1_reg, sync2_reg, sync3_reg, pin_reg} <= '0;
    end else begin
      sync1_reg <= {io_pad_in, pin_light_load, pin_select, pin_enable};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      for (int b = 0; b < PIN_W; b++) begin
        if (sync2_reg[b] == sync3_reg[b]) begin
          pin_reg[b] <= sync3_reg[b];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  assign step_time = config_reg[`BRC_CFG_STEP_LSB +: 8];

  assign wr_setting = bus_req.wr && power_active;

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      enable_reg <= 32'h0000_0000;
      config_reg <= `BRC_CFG_RESET;
      mode_reg <= 32'h0000_0000;
      int_mask_reg <= 1'b0;
    end else if (bus_req.wr) begin
      case (bus_req.addr)
        `BRC_ADDR_ENABLE: enable_reg <= {16'h0000, bus_req.wdata[15:0]};
        `BRC_ADDR_CONFIG: config_reg <= {16'h0000, bus_req.wdata[15:0]};
        `BRC_ADDR_MODE: mode_reg <= {16'h0000, bus_req.wdata[15:0]};
        `BRC_ADDR_INT_MASK: int_mask_reg <= bus_req.wdata[0];
        default: ;
      endcase
    end
  end

  // Voltage settings, one word each
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      set_a_reg <= '0;
      set_b_reg <= '0;
    end else if (wr_setting) begin
      for (int i = 0; i < NUM_CONV; i++) begin
        if (bus_req.addr == `BRC_ADDR_SET_A_BASE + 8'(4 * i)) begin
          set_a_reg[i] <= bus_req.wdata[CODE_W-1:0];
        end
        if (bus_req.addr == `BRC_ADDR_SET_B_BASE + 8'(4 * i)) begin
          set_b_reg[i] <= bus_req.wdata[CODE_W-1:0];
        end
      end
    end
  end

  // Shared step timer
  logic [15:0] step_cnt_reg, step_limit;
  logic step_tick;

  assign step_limit = 16'((16'(step_time) + 16'h0001) * `BRC_STEP_UNIT_CYC - 1);
  assign step_tick = (step_cnt_reg >= step_limit);

  always_ff @(posedge ref_clk) begin
    if (!rst_n || step_tick) begin
      step_cnt_reg <= 16'h0000;
    end else begin
      step_cnt_reg <= step_cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // Per-converter control and ramp
  // ----------------------------------------------------------------
  brc_pkg::brc_conv_ctrl_t [NUM_CONV-1:0] ctrl, eff;
  logic [NUM_CONV-1:0][CODE_W-1:0] code_reg;
  logic [NUM_CONV-1:0] on_reg, pfm_reg, busy, use_b;
  logic [NUM_CONV-1:0][1:0] ilim_reg;
  logic slow_start, discharge;

  assign slow_start = config_reg[`BRC_CFG_SLOW_START];
  assign discharge = config_reg[`BRC_CFG_DISCHARGE];

  generate
    for (genvar g = 0; g < NUM_CONV; g++) begin : g_conv
      logic [CODE_W-1:0] target, setting;
      logic want_on;

      // Gather the software fields of this converter
      assign ctrl[g].en = enable_reg[g];
      assign ctrl[g].sel = enable_reg[NUM_CONV + g];
      assign ctrl[g].sl_a = enable_reg[2 * NUM_CONV + g];
      assign ctrl[g].sl_b = enable_reg[3 * NUM_CONV + g];
      assign ctrl[g].mode = mode_reg[2 * g +: 2];
      assign ctrl[g].ilim = mode_reg[2 * NUM_CONV + 2 * g +: 2];

      // second converter follows first when merged
      assign eff[g] = (g == 1 && dual_phase_merge) ? ctrl[0] : ctrl[g];

      // any enable source turns it on
      assign want_on = eff[g].en || pin_reg[g] || seq_enable[g];

      // setting select from bit, pin or power mode
      assign use_b[g] = eff[g].sel || pin_reg[NUM_CONV + g] || seq_select_b[g];

      // Merged pair also shares the first converter's settings
      assign setting = (g == 1 && dual_phase_merge) ?
        (use_b[g] ? set_b_reg[0] : set_a_reg[0]) :
        (use_b[g] ? set_b_reg[g] : set_a_reg[g]);
      assign target = want_on ? setting : '0;
      assign busy[g] = on_reg[g] && (code_reg[g] != target);

      // Ramp engine; one code step per tick, never a jump while running
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          code_reg[g] <= '0;
          on_reg[g] <= 1'b0;
        end else if (!on_reg[g]) begin
          if (want_on) begin
            on_reg[g] <= 1'b1;
            // fast start jumps, slow start ramps from zero
            code_reg[g] <= slow_start ? '0 : setting;
          end
        end else if (!want_on && !discharge) begin
          // Rail is simply released, no controlled discharge
          on_reg[g] <= 1'b0;
          code_reg[g] <= '0;
        end else if (!want_on && code_reg[g] == '0) begin
          on_reg[g] <= 1'b0;
        end else if (step_tick && code_reg[g] != target) begin
          if (code_reg[g] < target) begin
            code_reg[g] <= code_reg[g] + 1'b1;
          end else begin
            code_reg[g] <= code_reg[g] - 1'b1;
          end
        end
      end

      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          pfm_reg[g] <= 1'b0;
        end else if ((use_b[g] && eff[g].sl_b) ||
                     (!use_b[g] && eff[g].sl_a)) begin
          pfm_reg[g] <= 1'b1;
        end else begin
          case (eff[g].mode)
            `BRC_MODE_PWM: pfm_reg[g] <= 1'b0;
            `BRC_MODE_PFM: pfm_reg[g] <= 1'b1;
            default: pfm_reg[g] <= pin_reg[2 * NUM_CONV + g];
          endcase
        end
      end

      // limit passed to the analog loop only
      always_ff @(posedge ref_clk) begin
        ilim_reg[g] <= rst_n ? eff[g].ilim : 2'h0;
      end
    end
  endgenerate

  // Ready event and interrupt
  logic any_busy_reg, ready_pulse, irq_reg;

  // falling edge of any ramp busy
  assign ready_pulse = any_busy_reg && !(|busy);

  // Busy history for the edge detect
  always_ff @(posedge ref_clk) begin
    any_busy_reg <= rst_n && (|busy);
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      int_status_reg <= 1'b0;
    end else if (ready_pulse) begin
      int_status_reg <= 1'b1;
    end else if (bus_req.wr && bus_req.addr == `BRC_ADDR_INT_STATUS &&
                 bus_req.wdata[0]) begin
      int_status_reg <= 1'b0;
    end
  end

  // Level interrupt, one cycle behind the flag
  always_ff @(posedge ref_clk) begin
    irq_reg <= rst_n && int_status_reg && int_mask_reg;
  end

  // ----------------------------------------------------------------
  // Current mode, termination and pin muxing
  // ----------------------------------------------------------------
  logic term_en, term_ref_en, pd_dis_reg, pin0_analog_reg, pin1_analog_reg;
  logic [1:0] fcm_reg, pad_out_reg, pad_oe_reg, dig_in_reg, analog;
  brc_pkg::brc_ref_t ref_reg;

  assign term_en = config_reg[`BRC_CFG_TERM_EN];
  assign term_ref_en = config_reg[`BRC_CFG_TERM_REF_EN];
  assign analog = {term_ref_en, term_en || term_ref_en};

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {fcm_reg, pd_dis_reg} <= 3'h0;
    end else begin
      fcm_reg[0] <= config_reg[`BRC_CFG_FIRST_FCM];
      fcm_reg[1] <= dual_phase_merge ? config_reg[`BRC_CFG_FIRST_FCM] :
                    config_reg[`BRC_CFG_SECOND_FCM];
      pd_dis_reg <= config_reg[`BRC_CFG_SECOND_PD_DIS];
    end
  end

  // PWM for termination is left to software
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ref_reg <= brc_pkg::BRC_REF_DAC;
    end else if (term_en && term_ref_en) begin
      ref_reg <= brc_pkg::BRC_REF_HALF_BUF;
    end else if (term_en) begin
      ref_reg <= brc_pkg::BRC_REF_HALF_RAW;
    end else begin
      ref_reg <= brc_pkg::BRC_REF_DAC;
    end
  end

  // digital paths blocked on analog pins
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      {pin0_analog_reg, pin1_analog_reg} <= 2'h0;
      {pad_out_reg, pad_oe_reg, dig_in_reg} <= 6'h00;
    end else begin
      pin0_analog_reg <= analog[0];
      pin1_analog_reg <= analog[1];
      pad_out_reg <= io_dig_out & ~analog;
      pad_oe_reg <= io_dig_oe & ~analog;
      dig_in_reg <= pin_reg[3 * NUM_CONV +: 2] & ~analog;
    end
  end

  // ----------------------------------------------------------------
  // Read mux, data stands the cycle after the strobe
  // ----------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (bus_req.addr)
      `BRC_ADDR_ENABLE: rdata_next = enable_reg;
      `BRC_ADDR_CONFIG: rdata_next = config_reg;
      `BRC_ADDR_MODE: rdata_next = mode_reg;
      `BRC_ADDR_INT_STATUS: rdata_next = {31'h0, int_status_reg};
      `BRC_ADDR_INT_MASK: rdata_next = {31'h0, int_mask_reg};
      `BRC_ADDR_STATUS:
        rdata_next = {23'h0, dual_phase_merge, 4'(busy), 4'(on_reg)};
      `BRC_ADDR_RESOLUTION:
        rdata_next = {`BRC_STEP_MV_NORMAL, `BRC_STEP_MV_THIRD,
                      `BRC_STEP_MV_NORMAL, `BRC_STEP_MV_NORMAL};
      default: begin
        for (int i = 0; i < NUM_CONV; i++) begin
          if (bus_req.addr == `BRC_ADDR_SET_A_BASE + 8'(4 * i)) begin
            rdata_next = 32'(set_a_reg[i]);
          end
          if (bus_req.addr == `BRC_ADDR_SET_B_BASE + 8'(4 * i)) begin
            rdata_next = 32'(set_b_reg[i]);
          end
          if (bus_req.addr == `BRC_ADDR_CODE_BASE + 8'(4 * i)) begin
            rdata_next = 32'(code_reg[i]);
          end
        end
      end
    endcase
  end

  // Unread cycles return zero so stale data never lingers
  always_ff @(posedge ref_clk) begin
    rdata_reg <= (rst_n && bus_req.rd) ? rdata_next : 32'h0000_0000;
  end

  // Outputs, all straight from flops
  assign bus_rdata = rdata_reg;
  assign conv_code = code_reg;
  assign {conv_on, conv_pfm} = {on_reg, pfm_reg};
  assign peak_current_limit = ilim_reg;
  assign full_current_select = fcm_reg;
  assign second_pulldown_disable = pd_dis_reg;
  assign fourth_ref_select = ref_reg;
  assign io_pin_zero_analog = pin0_analog_reg;
  assign io_pin_one_analog = pin1_analog_reg;
  assign io_pad_out = pad_out_reg;
  assign io_pad_oe = pad_oe_reg;
  assign io_dig_in = dig_in_reg;
  assign irq = irq_reg;

endmodule : brc_buck_control

/* File: verification/brc_chk.sv */
// Port-level assertions for the buck regulator control block
`timescale 1ns/1ps

module brc_chk #(
  parameter int NUM_CONV = 4,
  parameter int CODE_W = 8
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic dual_phase_merge,
  input wire logic [1:0] io_pad_out,
  input wire logic [1:0] io_pad_oe,
  input wire logic [1:0] io_dig_in,
  input wire logic [NUM_CONV-1:0][CODE_W-1:0] conv_code,
  input wire logic [NUM_CONV-1:0] conv_on,
  input wire logic [NUM_CONV-1:0][1:0] peak_current_limit,
  input wire logic [1:0] full_current_select,
  input wire brc_pkg::brc_ref_t fourth_ref_select,
  input wire logic io_pin_zero_analog,
  input wire logic io_pin_one_analog,
  input wire logic irq
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // Ramp stepping
  // ----------------------------------------------------------------
  // Turn-on jumps are excluded through the past on flag
  step_one_a: assert property (
    conv_on[0] && $past(conv_on[0]) && $changed(conv_code[0]) |->
    (conv_code[0] == $past(conv_code[0]) + 1'b1) ||
    (conv_code[0] == $past(conv_code[0]) - 1'b1))
    else $error("code moved by more than one step");
  // Shortest step time is twelve cycles, so eight quiet ones at least
  step_gap_a: assert property (
    conv_on[0] && $past(conv_on[0]) && $changed(conv_code[0]) |=>
    $stable(conv_code[0]) [*8])
    else $error("code steps closer than the step time");

  // ----------------------------------------------------------------
  // Analog pins and reference
  // ----------------------------------------------------------------
  // One cycle of slack for the pad mask to follow the flag
  pad_zero_a: assert property (
    io_pin_zero_analog && $past(io_pin_zero_analog) |->
    !io_pad_oe[0] && !io_pad_out[0] && !io_dig_in[0])
    else $error("pin zero digital while analog");
  pad_one_a: assert property (
    io_pin_one_analog && $past(io_pin_one_analog) |->
    !io_pad_oe[1] && !io_pad_out[1] && !io_dig_in[1])
    else $error("pin one digital while analog");
  ref_dac_a: assert property (
    !io_pin_zero_analog && $past(!io_pin_zero_analog) |->
    fourth_ref_select == brc_pkg::BRC_REF_DAC)
    else $error("termination reference without termination bits");
  ref_buf_a: assert property (
    (fourth_ref_select == brc_pkg::BRC_REF_HALF_BUF) [*2] |->
    io_pin_zero_analog && io_pin_one_analog)
    else $error("buffered reference without both analog pins");
  ref_raw_a: assert property (
    (fourth_ref_select == brc_pkg::BRC_REF_HALF_RAW) [*2] |->
    io_pin_zero_analog && !io_pin_one_analog)
    else $error("unbuffered reference with wrong pin use");

  // ----------------------------------------------------------------
  // Dual-phase merge
  // ----------------------------------------------------------------
  merge_follow_a: assert property (
    dual_phase_merge [*3] |->
    full_current_select[1] == full_current_select[0] &&
    peak_current_limit[1] == peak_current_limit[0])
    else $error("second converter not following first");

  // Main scenarios reached
  cover property (conv_on[0] && $changed(conv_code[0]));
  cover property ($rose(irq));
  cover property (fourth_ref_select == brc_pkg::BRC_REF_HALF_BUF);
  cover property ($rose(dual_phase_merge));
endmodule : brc_chk

/* File: verification/tb.sv */
// Self-checking bench for the buck regulator control block
`timescale 1ns/1ps
`include "brc_defines.svh"

module tb;
  logic ref_clk;
  logic rst_n;
  brc_pkg::brc_bus_req_t bus_req;
  logic [31:0] bus_rdata;
  logic [3:0] pin_enable, pin_select, pin_light_load, seq_enable;
  logic [3:0] seq_select_b, conv_on, conv_pfm;
  logic power_active, dual_phase_merge, second_pulldown_disable;
  logic io_pin_zero_analog, io_pin_one_analog, irq;
  logic [1:0] io_pad_in, io_dig_out, io_dig_oe, io_pad_out, io_pad_oe;
  logic [1:0] io_dig_in, full_current_select;
  logic [3:0][7:0] conv_code;
  logic [3:0][1:0] peak_current_limit;
  brc_pkg::brc_ref_t fourth_ref_select;
  int bad_count, tests_run, n;

  brc_buck_control #(.NUM_CONV(4), .CODE_W(8)) i_dut (
    .ref_clk, .rst_n, .bus_req, .bus_rdata, .pin_enable, .pin_select,
    .pin_light_load, .seq_enable, .seq_select_b, .power_active,
    .dual_phase_merge, .io_pad_in, .io_dig_out, .io_dig_oe, .io_pad_out,
    .io_pad_oe, .io_dig_in, .conv_code, .conv_on, .conv_pfm,
    .peak_current_limit, .full_current_select, .second_pulldown_disable,
    .fourth_ref_select, .io_pin_zero_analog, .io_pin_one_analog, .irq);

  // Free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
    tests_run++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk) bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge ref_clk) bus_req.wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task rchk(input logic [7:0] a, input logic [31:0] e, input string m);
    @(posedge ref_clk) bus_req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge ref_clk) bus_req.rd <= 1'b0;
    #1 chk(bus_rdata, e, m);
  endtask : rchk
  task wcyc(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask : wcyc
  // Counts edges until the code arrives, bounded
  task wait_code(input int i, input logic [7:0] v, input int lim);
    n = 0;
    while (conv_code[i] !== v && n < lim) begin
      @(posedge ref_clk);
      #1 n++;
    end
    chk(conv_code[i], v, "code target missed");
  endtask : wait_code

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_regs;
    rchk(`BRC_ADDR_CONFIG, 32'h0000_000c, "config reset");
    chk(full_current_select, 2'h3, "full current at reset");
    wr(`BRC_ADDR_RESOLUTION, 32'h0);
    rchk(`BRC_ADDR_RESOLUTION, 32'h0a14_0a0a, "resolution");
    rchk(8'hfc, 32'h0, "unmapped read");
    rchk(`BRC_ADDR_INT_MASK, 32'h0, "mask reset");
    $display("t_regs done");
  endtask : t_regs

  task t_refuse;
    @(posedge ref_clk) power_active <= 1'b0;
    wr(`BRC_ADDR_SET_A_BASE, 32'h33);
    rchk(`BRC_ADDR_SET_A_BASE, 32'h0, "write taken outside active");
    @(posedge ref_clk) power_active <= 1'b1;
    wr(`BRC_ADDR_SET_A_BASE, 32'h10);
    rchk(`BRC_ADDR_SET_A_BASE, 32'h10, "write lost in active");
    wr(8'h24, 32'h1ff);
    rchk(8'h24, 32'hff, "setting width");
    $display("t_refuse done");
  endtask : t_refuse

  task t_fast;
    wr(`BRC_ADDR_ENABLE, 32'h1);
    wcyc(2);
    chk({conv_on[0], conv_code[0]}, 9'h110, "register enable");
    @(posedge ref_clk) pin_enable <= 4'h2;
    wcyc(8);
    chk({conv_on[1], conv_code[1]}, 9'h1ff, "pin enable");
    @(posedge ref_clk) pin_enable <= 4'h0;
    wcyc(8);
    chk({conv_on[1], conv_code[1]}, 9'h0, "pin disable");
    @(posedge ref_clk) seq_enable <= 4'h4;
    wcyc(3);
    chk(conv_on[2], 1'b1, "sequencer enable");
    @(posedge ref_clk) seq_enable <= 4'h0;
    $display("t_fast done");
  endtask : t_fast

  task t_ramp;
    wr(`BRC_ADDR_INT_STATUS, 32'h1);
    wr(`BRC_ADDR_INT_MASK, 32'h1);
    wr(`BRC_ADDR_SET_A_BASE, 32'h13);
    wait_code(0, 8'h11, 40);
    wait_code(0, 8'h12, 40);
    chk(n, 12, "step time zero");
    wait_code(0, 8'h13, 40);
    chk(n, 12, "step time zero");
    wcyc(4);
    chk(irq, 1'b1, "ready interrupt");
    rchk(`BRC_ADDR_INT_STATUS, 32'h1, "ready status");
    wr(`BRC_ADDR_INT_STATUS, 32'h1);
    wcyc(3);
    chk(irq, 1'b0, "ready clear");
    wcyc(40);
    rchk(`BRC_ADDR_INT_STATUS, 32'h0, "ready fired twice");
    // Longer step time, walked downwards
    wr(`BRC_ADDR_CONFIG, 32'h10c);
    wr(`BRC_ADDR_SET_A_BASE, 32'h11);
    wait_code(0, 8'h12, 60);
    wait_code(0, 8'h11, 60);
    chk(n, 24, "step time one");
    wr(`BRC_ADDR_CONFIG, 32'h0c);
    $display("t_ramp done");
  endtask : t_ramp

  task t_select;
    wr(`BRC_ADDR_SET_B_BASE, 32'h12);
    wr(`BRC_ADDR_ENABLE, 32'h11);
    wait_code(0, 8'h12, 40);
    wr(`BRC_ADDR_ENABLE, 32'h1);
    wait_code(0, 8'h11, 40);
    wr(`BRC_ADDR_MODE, 32'h1);
    wr(`BRC_ADDR_ENABLE, 32'h1011);
    wcyc(2);
    chk(conv_pfm[0], 1'b1, "sleep on B");
    wr(`BRC_ADDR_ENABLE, 32'h1001);
    wcyc(2);
    chk(conv_pfm[0], 1'b0, "sleep on B with A");
    @(posedge ref_clk) pin_select <= 4'h1;
    wcyc(8);
    chk(conv_pfm[0], 1'b1, "pin selects B");
    @(posedge ref_clk) pin_select <= 4'h0;
    wcyc(8);
    @(posedge ref_clk) seq_select_b <= 4'h1;
    wcyc(3);
    chk(conv_pfm[0], 1'b1, "power mode selects B");
    @(posedge ref_clk) seq_select_b <= 4'h0;
    wr(`BRC_ADDR_ENABLE, 32'h0101);
    wcyc(2);
    chk(conv_pfm[0], 1'b1, "sleep on A");
    wr(`BRC_ADDR_ENABLE, 32'h1);
    $display("t_select done");
  endtask : t_select

  task t_mode;
    wr(`BRC_ADDR_MODE, 32'he401);
    wcyc(2);
    chk(conv_pfm[0], 1'b0, "forced pwm");
    chk(peak_current_limit, 8'he4, "current limit");
    chk(conv_on[0], 1'b1, "limit stops nothing");
    wr(`BRC_ADDR_MODE, 32'he402);
    wcyc(2);
    chk(conv_pfm[0], 1'b1, "forced sleep");
    @(posedge ref_clk) pin_light_load <= 4'h1;
    wr(`BRC_ADDR_MODE, 32'he400);
    wcyc(6);
    chk(conv_pfm[0], 1'b1, "auto light load");
    @(posedge ref_clk) pin_light_load <= 4'h0;
    wcyc(6);
    chk(conv_pfm[0], 1'b0, "auto heavy load");
    $display("t_mode done");
  endtask : t_mode

  task t_discharge;
    wr(`BRC_ADDR_CONFIG, 32'h0e);
    wr(`BRC_ADDR_ENABLE, 32'h0);
    wcyc(3);
    chk(conv_on[0], 1'b1, "runs while discharging");
    wait_code(0, 8'h00, 300);
    wcyc(8);
    chk(conv_on[0], 1'b0, "off after discharge");
    wr(`BRC_ADDR_CONFIG, 32'h0c);
    wr(`BRC_ADDR_ENABLE, 32'h1);
    wcyc(2);
    chk({conv_on[0], conv_code[0]}, 9'h111, "fast start");
    wr(`BRC_ADDR_ENABLE, 32'h0);
    wcyc(2);
    chk({conv_on[0], conv_code[0]}, 9'h0, "plain off");
    $display("t_discharge done");
  endtask : t_discharge

  task t_slow;
    wr(`BRC_ADDR_INT_STATUS, 32'h1);
    wr(`BRC_ADDR_INT_MASK, 32'h0);
    wr(`BRC_ADDR_CONFIG, 32'h0d);
    wr(`BRC_ADDR_ENABLE, 32'h1);
    wcyc(2);
    chk(conv_code[0] < 8'h11, 1'b1, "slow start jumped");
    wait_code(0, 8'h11, 300);
    rchk(`BRC_ADDR_CODE_BASE, 32'h11, "code readback");
    wcyc(4);
    chk(irq, 1'b0, "masked interrupt");
    rchk(`BRC_ADDR_INT_STATUS, 32'h1, "sticky ready");
    wr(`BRC_ADDR_INT_MASK, 32'h1);
    wcyc(3);
    chk(irq, 1'b1, "unmasked interrupt");
    wr(`BRC_ADDR_INT_STATUS, 32'h1);
    wcyc(3);
    chk(irq, 1'b0, "interrupt cleared");
    wr(`BRC_ADDR_ENABLE, 32'h0);
    wr(`BRC_ADDR_CONFIG, 32'h0c);
    $display("t_slow done");
  endtask : t_slow

  task t_term;
    logic [1:0] k;
    brc_pkg::brc_ref_t rt [4];
    rt = '{brc_pkg::BRC_REF_DAC, brc_pkg::BRC_REF_HALF_RAW,
           brc_pkg::BRC_REF_DAC, brc_pkg::BRC_REF_HALF_BUF};
    wr(`BRC_ADDR_MODE, 32'h0040);
    for (int j = 0; j < 4; j++) begin
      k = j[1:0];
      wr(`BRC_ADDR_CONFIG, {25'h0, k, 5'h0c});
      wcyc(6);
      chk(fourth_ref_select, rt[j], "reference source");
      chk({io_pin_one_analog, io_pin_zero_analog}, {k[1], |k}, "pins");
      chk(io_pad_oe, {~k[1], ~|k}, "pad drive on analog");
      chk(io_pad_out, {~k[1], ~|k}, "pad out on analog");
      chk(io_dig_in, {~k[1], ~|k}, "pad input on analog");
    end
    wr(`BRC_ADDR_CONFIG, 32'h0c);
    $display("t_term done");
  endtask : t_term

  task t_merge;
    wr(`BRC_ADDR_CONFIG, 32'h18);
    wcyc(2);
    chk(full_current_select, 2'h2, "half current first");
    @(posedge ref_clk) dual_phase_merge <= 1'b1;
    wcyc(3);
    chk(full_current_select, 2'h0, "merged current mode");
    chk(second_pulldown_disable, 1'b1, "pull-down kept");
    wr(`BRC_ADDR_ENABLE, 32'h2);
    wcyc(2);
    chk(conv_on, 4'h0, "second enable ignored");
    wr(`BRC_ADDR_ENABLE, 32'h1);
    wcyc(2);
    chk(conv_on, 4'h3, "second follows first");
    wr(`BRC_ADDR_ENABLE, 32'h0);
    @(posedge ref_clk) dual_phase_merge <= 1'b0;
    $display("t_merge done");
  endtask : t_merge

  task end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : end_sim

  // Whole run is under a thousand cycles; the limit is twenty thousand
  initial begin
    #400000;
    bad_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // Reset, then the scenarios in order
  initial begin
    bus_req = '0;
    {pin_enable, pin_select, pin_light_load, seq_enable, seq_select_b} = '0;
    {io_pad_in, io_dig_out, io_dig_oe} = 6'h3f;
    {power_active, dual_phase_merge} = 2'h2;
    {bad_count, tests_run, n} = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_regs();
    t_refuse();
    t_fast();
    t_ramp();
    t_select();
    t_mode();
    t_discharge();
    t_slow();
    t_term();
    t_merge();
    end_sim();
  end
endmodule : tb

bind brc_buck_control brc_chk #(.NUM_CONV(NUM_CONV), .CODE_W(CODE_W)) i_chk (
  .ref_clk, .rst_n, .dual_phase_merge, .io_pad_out, .io_pad_oe, .io_dig_in,
  .conv_code, .conv_on, .peak_current_limit, .full_current_select,
  .fourth_ref_select, .io_pin_zero_analog, .io_pin_one_analog, .irq);
